// ---- design/stc_pkg.sv ----
// Purpose: Shared constants and types for the sweep trigger controller.
// Assumes: One 50 MHz clock, synchronous active-low reset.
// Notes:   Register offsets and CTRL and CMD field positions live here.
package stc_pkg;

   localparam int unsigned NCH           = 4;
   localparam int unsigned CHW           = 2;
   localparam int unsigned CLK_NS        = 20;
   localparam int unsigned CNT_W         = 24;
   localparam int unsigned PT_W          = 16;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL       = 4'h0;
   localparam logic [3:0] REG_CMD        = 4'h1;
   localparam logic [3:0] REG_TRIG_DLY   = 4'h2;
   localparam logic [3:0] REG_SWP_DLY    = 4'h3;
   localparam logic [3:0] REG_MEAS_TIME  = 4'h4;
   localparam logic [3:0] REG_POINTS     = 4'h5;
   localparam logic [3:0] REG_DISP       = 4'h6;
   localparam logic [3:0] REG_STATUS     = 4'h7;
   localparam logic [3:0] REG_MODES      = 4'h8;

   // CTRL fields.
   localparam int unsigned CTRL_SRC_LSB  = 0;
   localparam int unsigned CTRL_POS_BIT  = 2;
   localparam int unsigned CTRL_PT_BIT   = 3;
   localparam int unsigned CTRL_ACT_BIT  = 4;
   localparam int unsigned CTRL_ACH_LSB  = 8;

   // CMD fields (write-only pulses).
   localparam int unsigned CMD_SET_BIT   = 0;
   localparam int unsigned CMD_MODE_LSB  = 1;
   localparam int unsigned CMD_HOLDALL   = 3;
   localparam int unsigned CMD_CONTDISP  = 4;
   localparam int unsigned CMD_SWTRIG    = 5;

   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [31:0] DLY_RST       = 32'h0000_0000;
   localparam logic [31:0] MEAS_RST      = 32'h0000_0010;
   localparam logic [31:0] POINTS_RST    = 32'h0000_0004;

   typedef enum logic [1:0] {
      STC_SRC_INT,
      STC_SRC_EXT,
      STC_SRC_MAN,
      STC_SRC_BUS
   } stc_src_t;

   typedef enum logic [1:0] {
      STC_MODE_HOLD,
      STC_MODE_SINGLE,
      STC_MODE_CONT
   } stc_mode_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } stc_bus_t;

endpackage

// ---- design/stc_delay.sv ----
// Purpose: Loadable down-counter used for delays and point timing.
// Assumes: Load and count share the one clock.
// Notes:   done pulses one cycle when the loaded count runs out.
`timescale 1ns/10ps
module stc_delay (
   input  wire logic                     mclk,
   input  wire logic                     nrst,
   input  wire logic                     load,
   input  wire logic [stc_pkg::CNT_W-1:0] count,
   output logic                          busy,
   output logic                          done
);
   logic [stc_pkg::CNT_W-1:0] cnt_q;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cnt_q <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else if (load) begin
         cnt_q <= count;
         busy  <= 1'b1;
         done  <= 1'b0;
      end else if (busy) begin
         // A zero count still costs one cycle, so done is never lost.
         if (cnt_q == '0) begin
            busy <= 1'b0;
            done <= 1'b1;
         end else begin
            cnt_q <= cnt_q - 1'b1;
            done  <= 1'b0;
         end
      end else begin
         done <= 1'b0;
      end
   end
endmodule

// ---- design/stc_top.sv ----
// Purpose: Sweep trigger controller: trigger detect, delays, point gating,
//          per-channel trigger modes and handler index output.
// Assumes: Pins are synchronous to mclk; software uses the plain port.
// Notes:   One sequencer measures all the selected channels together.
`timescale 1ns/10ps
// Function
// RL1: External trigger taken on rising or falling edge per polarity bit.
// RL2: Handler I/O trigger ignores polarity; always its own active edge.
// RL3: Trigger delay used only when the source is external.
// RL4: Trigger delay runs again before every point.
// RL5: Triggers during a point measurement are discarded.
// RL6: Next point starts only on a trigger after the point completes.
// RL7: Index high before first point, low after last, when point triggering.
// RL8: Each channel keeps its own trigger mode.
// RL9: Modes hold, single, continuous; commands set active channel mode.
// RL10: Hold-all command sets every channel to hold.
// RL11: Continuous-displayed command sets displayed channels continuous only.
// RL12: Active scope measures only the active channel.
// RL13: Changing active channel under active scope moves measurement.
// RL14: Continuous mode repeats sweeps until hold.
// RL15: Hold stops sweeping at once; code stops a sweep only once all its selected channels are held.
// RL16: Held channel ignores triggers until its mode changes.
// RL17: Point event measures one point per trigger, sweep event all.
// RL18: Point triggering inactive with internal source.
// RL19: After external trigger, count trigger delay then sweep delay.
module stc_top (
   input  wire logic                  mclk,
   input  wire logic                  nrst,
   input  wire logic [3:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata,
   input  wire logic                  ext_trig,
   input  wire logic                  hdl_trig_n,
   output logic                       hdl_index,
   output logic                       sampling,
   output logic      [stc_pkg::NCH-1:0] meas_ch
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   stc_pkg::stc_bus_t   bus;
   logic [31:0]         ctrl_q;
   logic [31:0]         tdly_q;
   logic [31:0]         sdly_q;
   logic [31:0]         mtime_q;
   logic [stc_pkg::PT_W-1:0] npts_q;
   logic [stc_pkg::NCH-1:0]  disp_q;
   stc_pkg::stc_mode_t  mode_q [stc_pkg::NCH];
   logic [stc_pkg::NCH-1:0]  armed_q;
   stc_pkg::stc_src_t   src;
   logic                pos_edge;
   logic                pt_on;
   logic                act_scope;
   logic [stc_pkg::CHW-1:0] act_ch;
   logic                cmd_wr;
   logic                sw_trig;
   logic                ext_q;
   logic                hdl_q;
   logic                ext_edge;
   logic                hdl_edge;
   logic                trig;
   logic [stc_pkg::NCH-1:0] sel_mask;
   logic [stc_pkg::NCH-1:0] sel_q;
   logic                sweep_end;

   assign bus       = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign src       = stc_pkg::stc_src_t'(ctrl_q[stc_pkg::CTRL_SRC_LSB +: 2]);
   assign pos_edge  = ctrl_q[stc_pkg::CTRL_POS_BIT];
   assign act_scope = ctrl_q[stc_pkg::CTRL_ACT_BIT];
   assign act_ch    = ctrl_q[stc_pkg::CTRL_ACH_LSB +: stc_pkg::CHW];
   assign pt_on     = ctrl_q[stc_pkg::CTRL_PT_BIT] && (src != stc_pkg::STC_SRC_INT); // RL18
   assign cmd_wr    = bus.wr && (bus.addr == stc_pkg::REG_CMD);
   assign sw_trig   = cmd_wr && bus.wdata[stc_pkg::CMD_SWTRIG];

   function automatic logic [31:0] pack_modes(input logic [2*stc_pkg::NCH-1:0] m);
      pack_modes = {{(32-2*stc_pkg::NCH){1'b0}}, m};
   endfunction

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ctrl_q  <= stc_pkg::CTRL_RST;
         tdly_q  <= stc_pkg::DLY_RST;
         sdly_q  <= stc_pkg::DLY_RST;
         mtime_q <= stc_pkg::MEAS_RST;
         npts_q  <= stc_pkg::POINTS_RST[stc_pkg::PT_W-1:0];
         disp_q  <= '1;
      end else if (bus.wr) begin
         if (bus.addr == stc_pkg::REG_CTRL) begin
            ctrl_q <= bus.wdata;
         end else if (bus.addr == stc_pkg::REG_TRIG_DLY) begin
            tdly_q <= bus.wdata;
         end else if (bus.addr == stc_pkg::REG_SWP_DLY) begin
            sdly_q <= bus.wdata;
         end else if (bus.addr == stc_pkg::REG_MEAS_TIME) begin
            mtime_q <= bus.wdata;
         end else if (bus.addr == stc_pkg::REG_POINTS) begin
            npts_q <= bus.wdata[stc_pkg::PT_W-1:0];
         end else if (bus.addr == stc_pkg::REG_DISP) begin
            disp_q <= bus.wdata[stc_pkg::NCH-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Trigger detection
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ext_q <= 1'b0;
         hdl_q <= 1'b1;
      end else begin
         ext_q <= ext_trig;
         hdl_q <= hdl_trig_n;
      end
   end

   assign ext_edge = pos_edge ? (ext_trig && !ext_q) : (!ext_trig && ext_q); // RL1
   assign hdl_edge = hdl_q && !hdl_trig_n; // RL2

   always_comb begin
      case (src)
         stc_pkg::STC_SRC_EXT: trig = ext_edge || hdl_edge;
         stc_pkg::STC_SRC_INT: trig = 1'b1;
         default:              trig = sw_trig;
      endcase
   end

   // ----------------------------------------------------------------
   // Channel modes
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < stc_pkg::NCH; g++) begin : g_ch
         always_ff @(posedge mclk) begin
            if (!nrst) begin
               mode_q[g]  <= stc_pkg::STC_MODE_HOLD;
               armed_q[g] <= 1'b0;
            end else if (cmd_wr && bus.wdata[stc_pkg::CMD_HOLDALL]) begin
               mode_q[g]  <= stc_pkg::STC_MODE_HOLD; // RL10
               armed_q[g] <= 1'b0;
            end else if (cmd_wr && bus.wdata[stc_pkg::CMD_CONTDISP] && disp_q[g]) begin
               mode_q[g]  <= stc_pkg::STC_MODE_CONT; // RL11
               armed_q[g] <= 1'b1;
            end else if (cmd_wr && bus.wdata[stc_pkg::CMD_SET_BIT] && act_ch == g) begin
               // RL9 RL8
               mode_q[g]  <= stc_pkg::stc_mode_t'(bus.wdata[stc_pkg::CMD_MODE_LSB +: 2]);
               armed_q[g] <= (bus.wdata[stc_pkg::CMD_MODE_LSB +: 2] != stc_pkg::STC_MODE_HOLD); // RL16
            end else if (sweep_end && sel_q[g] && mode_q[g] == stc_pkg::STC_MODE_SINGLE) begin
               mode_q[g]  <= stc_pkg::STC_MODE_HOLD;
               armed_q[g] <= 1'b0;
            end
         end
         // RL12 RL13 RL16
         assign sel_mask[g] = armed_q[g] && (mode_q[g] != stc_pkg::STC_MODE_HOLD) &&
                              (!act_scope || act_ch == g);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Sweep sequencer
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      STC_IDLE,
      STC_TDLY,
      STC_SDLY,
      STC_MEAS,
      STC_WAIT
   } stc_state_t;

   stc_state_t              st_q;
   logic [stc_pkg::PT_W-1:0] pt_q;
   logic                    dly_load;
   logic [stc_pkg::CNT_W-1:0] dly_cnt;
   logic                    dly_busy;
   logic                    dly_done;
   logic                    hold_hit;
   logic                    last_pt;

   assign last_pt   = (pt_q + 1'b1 >= npts_q);
   assign sweep_end = (st_q == STC_MEAS) && dly_done && last_pt;
   assign hold_hit  = (st_q != STC_IDLE) && ((sel_q & sel_mask) == '0); // RL15

   stc_delay u_dly (
      .mclk  (mclk),
      .nrst  (nrst),
      .load  (dly_load),
      .count (dly_cnt),
      .busy  (dly_busy),
      .done  (dly_done)
   );

   function automatic logic [stc_pkg::CNT_W-1:0] trig_dly(input stc_pkg::stc_src_t s, input logic [31:0] d);
      trig_dly = (s == stc_pkg::STC_SRC_EXT) ? d[stc_pkg::CNT_W-1:0] : '0;
   endfunction

   always_comb begin
      dly_load = 1'b0;
      dly_cnt  = '0;
      case (st_q)
         STC_IDLE, STC_WAIT: begin
            // RL5 RL6: a trigger counts only once the point has completed.
            if (trig && !hold_hit && (st_q == STC_WAIT || sel_mask != '0)) begin
               dly_load = 1'b1;
               dly_cnt  = trig_dly(src, tdly_q); // RL3 RL4 RL19
            end
         end
         STC_TDLY: begin
            if (dly_done) begin
               dly_load = 1'b1;
               dly_cnt  = sdly_q[stc_pkg::CNT_W-1:0]; // RL19
            end
         end
         STC_SDLY: begin
            if (dly_done) begin
               dly_load = 1'b1;
               dly_cnt  = mtime_q[stc_pkg::CNT_W-1:0];
            end
         end
         STC_MEAS: begin
            // Per-sweep points skip the trigger wait but still run the trigger delay.
            if (dly_done && !last_pt && !pt_on) begin
               dly_load = 1'b1;
               dly_cnt  = trig_dly(src, tdly_q); // RL4
            end
         end
         default: begin
            dly_load = 1'b0;
            dly_cnt  = '0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_q      <= STC_IDLE;
         sel_q     <= '0;
         pt_q      <= '0;
         hdl_index <= 1'b0;
         sampling  <= 1'b0;
         meas_ch   <= '0;
      end else if (hold_hit) begin
         st_q      <= STC_IDLE; // RL15
         hdl_index <= 1'b0;
         sampling  <= 1'b0;
         meas_ch   <= '0;
      end else begin
         case (st_q)
            STC_IDLE: begin
               if (dly_load) begin
                  st_q      <= STC_TDLY;
                  sel_q     <= sel_mask;
                  pt_q      <= '0;
                  hdl_index <= pt_on; // RL7
               end
            end
            STC_WAIT: begin
               if (dly_load) begin
                  st_q <= STC_TDLY;
               end
            end
            STC_TDLY: begin
               if (dly_done) begin
                  st_q <= STC_SDLY;
               end
            end
            STC_SDLY: begin
               if (dly_done) begin
                  st_q     <= STC_MEAS;
                  sampling <= 1'b1;
                  meas_ch  <= sel_q;
               end
            end
            STC_MEAS: begin
               if (dly_done) begin
                  sampling <= 1'b0;
                  meas_ch  <= '0;
                  if (last_pt) begin
                     hdl_index <= 1'b0; // RL7
                     pt_q      <= '0;
                     // RL14: continuous channels rearm for another sweep.
                     st_q      <= STC_IDLE;
                  end else begin
                     pt_q <= pt_q + 1'b1;
                     st_q <= pt_on ? STC_WAIT : STC_TDLY; // RL17
                  end
               end
            end
            default: st_q <= STC_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   logic [2*stc_pkg::NCH-1:0] modes_flat;
   always_comb begin
      for (int i = 0; i < stc_pkg::NCH; i++) begin
         modes_flat[2*i +: 2] = mode_q[i];
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else if (bus.rd) begin
         if (bus.addr == stc_pkg::REG_CTRL) begin
            reg_rdata <= ctrl_q;
         end else if (bus.addr == stc_pkg::REG_TRIG_DLY) begin
            reg_rdata <= tdly_q;
         end else if (bus.addr == stc_pkg::REG_SWP_DLY) begin
            reg_rdata <= sdly_q;
         end else if (bus.addr == stc_pkg::REG_MEAS_TIME) begin
            reg_rdata <= mtime_q;
         end else if (bus.addr == stc_pkg::REG_POINTS) begin
            reg_rdata <= {{(32-stc_pkg::PT_W){1'b0}}, npts_q};
         end else if (bus.addr == stc_pkg::REG_DISP) begin
            reg_rdata <= {{(32-stc_pkg::NCH){1'b0}}, disp_q};
         end else if (bus.addr == stc_pkg::REG_STATUS) begin
            reg_rdata <= {9'h000, pt_q, 1'b0, 4'(st_q), sampling, hdl_index};
         end else if (bus.addr == stc_pkg::REG_MODES) begin
            reg_rdata <= pack_modes(modes_flat);
         end else begin
            reg_rdata <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_hold_stops: assert property (@(posedge mclk) disable iff (!nrst) // RL15
      hold_hit |=> st_q == STC_IDLE && !sampling) else $error("hold did not stop sweep");
   a_index_off_idle: assert property (@(posedge mclk) disable iff (!nrst) // RL7
      (st_q == STC_IDLE && $past(st_q) == STC_IDLE) |-> !hdl_index) else $error("index high while idle");
   a_wait_no_sample: assert property (@(posedge mclk) disable iff (!nrst) // RL5
      st_q == STC_WAIT |-> !sampling) else $error("sampling while waiting");
   a_index_start: assert property (@(posedge mclk) disable iff (!nrst) // RL7
      (st_q == STC_IDLE && dly_load) |=> hdl_index == $past(pt_on)) else $error("index wrong at sweep start");
   a_point_wait: assert property (@(posedge mclk) disable iff (!nrst) // RL17
      (st_q == STC_MEAS && dly_done && !last_pt && pt_on && !hold_hit) |=> st_q == STC_WAIT) else $error("no wait");
   a_holdall_clear: assert property (@(posedge mclk) disable iff (!nrst) // RL10
      (cmd_wr && bus.wdata[stc_pkg::CMD_HOLDALL]) |=> sel_mask == '0) else $error("hold all left a channel");
   a_delay_running: assert property (@(posedge mclk) disable iff (!nrst) // RL19
      (st_q inside {STC_TDLY, STC_SDLY, STC_MEAS} && !dly_done) |-> dly_busy) else $error("delay counter idle");
endmodule

// ---- test/stc_trig_src.sv ----
// Purpose: Model of the external trigger source and handler automation.
// Assumes: Levels change just after a rising mclk edge.
// Notes:   The handler line idles high, as its pull-up would leave it.
`timescale 1ns/10ps
module stc_trig_src (
   input  wire logic mclk,
   output logic      ext_trig,
   output logic      hdl_trig_n
);
   initial begin
      ext_trig   = 1'b0;
      hdl_trig_n = 1'b1;
   end
   task automatic ext_level(input logic lvl, input int hold);
      @(posedge mclk);
      ext_trig <= lvl;
      repeat (hold) @(posedge mclk);
   endtask
   // The pulse is held several cycles so the edge detector cannot miss it.
   task automatic hdl_pulse(input int width);
      @(posedge mclk);
      hdl_trig_n <= 1'b0;
      repeat (width) @(posedge mclk);
      hdl_trig_n <= 1'b1;
   endtask
endmodule

// ---- test/stc_top_tb_top.sv ----
// Purpose: Self-checking bench for the sweep trigger controller.
// Assumes: Delays and point time in mclk cycles, modes packed 2 bits a channel.
// Notes:   Latencies are checked inside a small window above the delay sum, or from 1 to SD+8 cycles for the bus trigger.
`timescale 1ns/10ps
module stc_top_tb_top;
   localparam int TD = 40;
   localparam int SD = 5;
   localparam int MT = 10;
   localparam int NP = 3;
   logic        mclk;
   logic        nrst;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        ext_trig;
   logic        hdl_trig_n;
   logic        hdl_index;
   logic        sampling;
   logic [3:0]  meas_ch;
   logic        samp_q;
   int          n_samp;
   int          n_mismatch;
   int          num_checks;
   int          lat;
   int          base;
   logic [31:0] rv;

   stc_top uut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trig(ext_trig), .hdl_trig_n(hdl_trig_n),
      .hdl_index(hdl_index), .sampling(sampling), .meas_ch(meas_ch));
   stc_trig_src ptn (.mclk(mclk), .ext_trig(ext_trig), .hdl_trig_n(hdl_trig_n));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      samp_q <= sampling;
      if (sampling === 1'b1 && samp_q !== 1'b1) n_samp <= n_samp + 1;
   end

   // ----------------------------------------------------------------
   // Access and checking tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_samp(input int bound, output int n);
      n = -1;
      for (int i = 0; i < bound; i++) begin
         @(posedge mclk);
         #1;
         if (sampling === 1'b1) begin
            n = i + 1;
            break;
         end
      end
   endtask
   function automatic logic [31:0] cv(logic [1:0] src, logic pol, logic pt, logic act, logic [1:0] ach);
      return {22'h0, ach, 3'h0, act, pt, pol, src};
   endfunction
   task automatic set_mode(input logic [1:0] m);
      wr(stc_pkg::REG_CMD, {29'h0, m, 1'b1});
   endtask
   task automatic in_win(input int v, input int lo, input int hi);
      chk({31'h0, v >= lo && v <= hi}, 32'h1);
   endtask
   task automatic conclude;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #(20 * 40000);
      n_mismatch++;
      conclude();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      nrst = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
      n_samp = 0; n_mismatch = 0; num_checks = 0;
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      rd(stc_pkg::REG_POINTS, rv);
      chk(rv, stc_pkg::POINTS_RST);
      wr(stc_pkg::REG_POINTS, NP);
      wr(stc_pkg::REG_MEAS_TIME, MT);
      wr(stc_pkg::REG_TRIG_DLY, TD);
      wr(stc_pkg::REG_SWP_DLY, SD);
      for (int c = 0; c < 4; c++) begin
         wr(stc_pkg::REG_CTRL, cv(2'h0, 1'b0, 1'b0, 1'b0, c[1:0]));
         set_mode(2'(c % 3));
      end
      rd(stc_pkg::REG_MODES, rv);
      chk(rv, 32'h24);
      wr(stc_pkg::REG_DISP, 32'h5);
      wr(stc_pkg::REG_CMD, 32'h10);
      rd(stc_pkg::REG_MODES, rv);
      chk(rv, 32'h26);
      wr(stc_pkg::REG_CMD, 32'h8);
      rd(stc_pkg::REG_MODES, rv);
      chk(rv, 32'h0);
      $display("test modes done");

      wr(stc_pkg::REG_CTRL, cv(2'h1, 1'b0, 1'b0, 1'b0, 2'h0));
      set_mode(2'h1);
      base = n_samp;
      ptn.ext_level(1'b1, 80);
      chk(n_samp - base, 0);
      ptn.ext_level(1'b0, 0);
      wait_samp(TD + SD + 8, lat);
      in_win(lat, TD + SD, TD + SD + 8);
      repeat (300) @(posedge mclk);
      chk(n_samp - base, NP);
      wr(stc_pkg::REG_CTRL, cv(2'h1, 1'b1, 1'b0, 1'b0, 2'h0));
      set_mode(2'h1);
      ptn.ext_level(1'b1, 0);
      wait_samp(TD + SD + 8, lat);
      in_win(lat, TD + SD, TD + SD + 8);
      repeat (300) @(posedge mclk);
      set_mode(2'h1);
      base = n_samp;
      ptn.hdl_pulse(3);
      repeat (300) @(posedge mclk);
      chk(n_samp - base, NP);
      $display("test edges done");

      ptn.ext_level(1'b0, 2);
      wr(stc_pkg::REG_CTRL, cv(2'h1, 1'b1, 1'b1, 1'b0, 2'h0));
      set_mode(2'h1);
      for (int p = 0; p < NP; p++) begin
         base = n_samp;
         ptn.ext_level(1'b1, 0);
         wait_samp(TD + SD + 8, lat);
         in_win(lat, TD + SD, TD + SD + 8);
         chk({31'h0, hdl_index}, 32'h1);
         ptn.ext_level(1'b0, 1);
         ptn.ext_level(1'b1, 1);
         ptn.ext_level(1'b0, 100);
         chk(n_samp - base, 1);
      end
      repeat (5) @(posedge mclk);
      #1;
      chk({31'h0, hdl_index}, 32'h0);
      $display("test point trigger done");

      wr(stc_pkg::REG_CTRL, cv(2'h0, 1'b0, 1'b1, 1'b0, 2'h0));
      base = n_samp;
      set_mode(2'h1);
      repeat (30) @(posedge mclk);
      #1;
      chk({31'h0, hdl_index}, 32'h0);
      repeat (270) @(posedge mclk);
      chk(n_samp - base, NP);
      wr(stc_pkg::REG_CTRL, cv(2'h3, 1'b0, 1'b0, 1'b0, 2'h0));
      set_mode(2'h1);
      wr(stc_pkg::REG_CMD, 32'h20);
      wait_samp(SD + 8, lat);
      in_win(lat, 1, SD + 8);
      repeat (300) @(posedge mclk);
      $display("test sources done");

      for (int c = 0; c < 4; c++) begin
         wr(stc_pkg::REG_CTRL, cv(2'h0, 1'b0, 1'b0, 1'b1, c[1:0]));
         set_mode(2'h2);
      end
      wr(stc_pkg::REG_CTRL, cv(2'h0, 1'b0, 1'b0, 1'b1, 2'h2));
      repeat (200) @(posedge mclk);
      base = n_samp;
      wait_samp(100, lat);
      chk({28'h0, meas_ch}, 32'h4);
      repeat (600) @(posedge mclk);
      chk({31'h0, n_samp - base >= 2 * NP}, 32'h1);
      wr(stc_pkg::REG_CTRL, cv(2'h0, 1'b0, 1'b0, 1'b1, 2'h1));
      repeat (200) @(posedge mclk);
      wait_samp(100, lat);
      chk({28'h0, meas_ch}, 32'h2);
      wr(stc_pkg::REG_CMD, 32'h8);
      repeat (3) @(posedge mclk);
      #1;
      chk({31'h0, sampling}, 32'h0);
      base = n_samp;
      repeat (200) @(posedge mclk);
      chk(n_samp - base, 0);
      $display("test continuous and hold done");
      conclude();
   end
endmodule
